// ---- dma_dual_address_channel.sv ----
// Dual-address DMA channel engine with AXI4-Lite register slave
`default_nettype none
module dma_dual_address_channel
  import dma_dual_address_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NCH-1:0] extTransferRequestN,
  input wire logic [1:0] memBusWidth,
  output logic busReq,
  input wire logic busGrant,
  output logic sysValid,
  output logic sysWrite,
  output logic [31:0] sysAddr,
  output logic [1:0] sysSize,
  output logic [31:0] sysWdata,
  input wire logic [31:0] sysRdata,
  input wire logic sysReady,
  output logic [NCH-1:0] normalDoneIrq
);
  function automatic logic [1:0] sizeLog(input logic [1:0] code);
    sizeLog = !code[1] ? 2'd2 : (code == SIZE_16 ? 2'd1 : 2'd0);
  endfunction
  function automatic logic [1:0] logCode(input logic [1:0] lg);
    logCode = lg == 2'd2 ? 2'h0 : (lg == 2'd1 ? 2'h2 : 2'h3);
  endfunction
  function automatic logic [31:0] strbMerge(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      old[b*8 +: 8] = s[b] ? d[b*8 +: 8] : old[b*8 +: 8];
    end
    strbMerge = old;
  endfunction
  function automatic logic [31:0] stepAddr(input logic [31:0] a, input logic [1:0] mode,
                                           input logic [31:0] n);
    stepAddr = mode == STEP_INC ? a + n : (mode == STEP_DEC ? a - n : a);
  endfunction

  logic [31:0] ctl [NCH];
  logic [31:0] srcAddr [NCH];
  logic [31:0] dstAddr [NCH];
  logic [31:0] byteCount [NCH];
  logic [NCH-1:0] active, normalDone, abnormalDone, confErr;
  logic [NCH-1:0] reqSync1, reqSync2;
  engine_e state;
  logic [1:0] cur, beat;
  logic [31:0] dataHolding;

  // AXI4-Lite write side
  logic awHeld, wHeld;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  wire wrEn = awHeld && wHeld && !s_axi_bvalid;
  wire [1:0] wrCh = wrAddr[CH_ADDR_LSB +: 2];
  wire [2:0] wrReg = wrAddr[REG_ADDR_LSB +: 3];
  wire wrMapped = wrReg <= REG_COUNT;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= RESET_WORD;
      wrStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && !awHeld && !s_axi_awready;
      s_axi_wready <= s_axi_wvalid && !wHeld && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        wrAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end
      if (wrEn) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read side
  wire [1:0] rdCh = s_axi_araddr[CH_ADDR_LSB +: 2];
  wire [2:0] rdReg = s_axi_araddr[REG_ADDR_LSB +: 3];
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RESET_WORD;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        case (rdReg)
          REG_CONTROL: s_axi_rdata <= ctl[rdCh];
          REG_STATUS: s_axi_rdata <= {28'h0, confErr[rdCh], abnormalDone[rdCh],
                                      normalDone[rdCh], active[rdCh]};
          REG_SOURCE: s_axi_rdata <= srcAddr[rdCh];
          REG_DEST: s_axi_rdata <= dstAddr[rdCh];
          REG_COUNT: s_axi_rdata <= byteCount[rdCh];
          default: begin
            s_axi_rdata <= RESET_WORD;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Go decode and configuration check on the written control value
  wire [31:0] newCtl = strbMerge(ctl[wrCh], wrData, wrStrb);
  wire goAccept = wrEn && wrReg == REG_CONTROL && wrStrb[0] && wrData[CTL_GO] && !active[wrCh];
  wire [2:0] newUnit = 3'd1 << sizeLog(newCtl[CTL_UNIT_LSB +: 2]);
  wire [31:0] unitMask = {29'h0, newUnit - 3'd1};
  wire newIo = newCtl[CTL_SRC_IO] | newCtl[CTL_DST_IO];
  wire goErr = normalDone[wrCh] | abnormalDone[wrCh]
    | byteCount[wrCh] == 32'h0 | (byteCount[wrCh] & unitMask) != 32'h0
    | (srcAddr[wrCh] & unitMask) != 32'h0 | (dstAddr[wrCh] & unitMask) != 32'h0
    | (newCtl[CTL_SRC_IO] & newCtl[CTL_DST_IO])
    | (newIo & sizeLog(newCtl[CTL_PORT_LSB +: 2]) > sizeLog(newCtl[CTL_UNIT_LSB +: 2]))
    | newCtl[CTL_ADDR_MODE];

  // Engine view of the current channel
  wire [31:0] curCtl = ctl[cur];
  wire [1:0] unitLog = sizeLog(curCtl[CTL_UNIT_LSB +: 2]);
  wire [31:0] unitBytes = 32'd1 << unitLog;
  wire [1:0] memLog = sizeLog(memBusWidth) < unitLog ? sizeLog(memBusWidth) : unitLog;
  wire [1:0] portLog = sizeLog(curCtl[CTL_PORT_LSB +: 2]);
  wire phaseIo = state == ENG_WRITE ? curCtl[CTL_DST_IO] : curCtl[CTL_SRC_IO];
  wire [1:0] accLog = phaseIo ? portLog : memLog;
  wire [1:0] lastBeat = (2'd1 << (unitLog - accLog)) - 2'd1;
  wire [31:0] curCount = byteCount[cur];

  // Requests and lowest-number pick
  logic [NCH-1:0] reqVec;
  logic [1:0] pick;
  always_comb begin
    pick = 2'd0;
    for (int i = 0; i < NCH; i++) begin
      reqVec[i] = active[i] && (!ctl[i][CTL_EXT_REQ] || !reqSync2[i]);
    end
    for (int i = NCH - 1; i >= 0; i--) begin
      if (reqVec[i]) begin
        pick = 2'(i);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      reqSync1 <= '1;
      reqSync2 <= '1;
    end else begin
      reqSync1 <= extTransferRequestN;
      reqSync2 <= reqSync1;
    end
  end

  // Beat address and lanes; I/O address never moves between beats
  function automatic logic [31:0] beatAddr(input logic [31:0] base, input logic io,
                                           input logic [1:0] b, input logic [1:0] lg);
    beatAddr = io ? base : base + ({30'h0, b} << lg);
  endfunction
  function automatic logic [31:0] laneMask(input logic [1:0] lg);
    laneMask = lg == 2'd2 ? 32'hFFFFFFFF : (lg == 2'd1 ? 32'h0000FFFF : 32'h000000FF);
  endfunction
  wire [4:0] shiftBits = 5'({beat, 3'b000} << accLog);
  wire [1:0] wrLog = curCtl[CTL_DST_IO] ? portLog : memLog;

  // Transfer engine, all on rising clk edges
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= ENG_IDLE;
      cur <= 2'd0;
      beat <= 2'd0;
      busReq <= 1'b0;
      sysValid <= 1'b0;
      sysWrite <= 1'b0;
      sysAddr <= RESET_WORD;
      sysSize <= 2'h0;
      sysWdata <= RESET_WORD;
      dataHolding <= RESET_WORD;
    end else begin
      case (state)
        ENG_IDLE: begin
          if (|reqVec) begin
            cur <= pick;
            busReq <= 1'b1;
            state <= ENG_ARB;
          end
        end
        ENG_ARB: begin
          if (busGrant) begin
            state <= ENG_READ;
            beat <= 2'd0;
            dataHolding <= RESET_WORD;
            sysValid <= 1'b1;
            sysWrite <= 1'b0;
            sysAddr <= srcAddr[cur];
            sysSize <= logCode(accLog);
          end
        end
        ENG_READ: begin
          if (sysReady) begin
            dataHolding <= dataHolding | ((sysRdata & laneMask(accLog)) << shiftBits);
            if (beat == lastBeat) begin
              state <= ENG_WRITE;
              beat <= 2'd0;
              sysWrite <= 1'b1;
              sysAddr <= dstAddr[cur];
              sysSize <= logCode(wrLog);
              sysWdata <= (dataHolding | ((sysRdata & laneMask(accLog)) << shiftBits))
                          & laneMask(wrLog);
            end else begin
              beat <= beat + 2'd1;
              sysAddr <= beatAddr(srcAddr[cur], curCtl[CTL_SRC_IO], beat + 2'd1, accLog);
            end
          end
        end
        ENG_WRITE: begin
          if (sysReady) begin
            if (beat == lastBeat) begin
              state <= ENG_STEP;
              sysValid <= 1'b0;
              sysWrite <= 1'b0;
            end else begin
              beat <= beat + 2'd1;
              sysAddr <= beatAddr(dstAddr[cur], curCtl[CTL_DST_IO], beat + 2'd1, accLog);
              sysWdata <= (dataHolding >> 5'(shiftBits + (5'd8 << accLog))) & laneMask(accLog);
            end
          end
        end
        ENG_STEP: begin
          busReq <= 1'b0;
          state <= ENG_IDLE;
        end
        default: state <= ENG_IDLE;
      endcase
    end
  end

  // Channel registers: software writes while idle, engine steps after each unit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        ctl[i] <= RESET_WORD;
        srcAddr[i] <= RESET_WORD;
        dstAddr[i] <= RESET_WORD;
        byteCount[i] <= RESET_WORD;
      end
    end else begin
      if (wrEn && !active[wrCh]) begin
        case (wrReg)
          REG_CONTROL: ctl[wrCh] <= newCtl & CTL_WRITE_MASK;
          REG_SOURCE: srcAddr[wrCh] <= strbMerge(srcAddr[wrCh], wrData, wrStrb);
          REG_DEST: dstAddr[wrCh] <= strbMerge(dstAddr[wrCh], wrData, wrStrb);
          REG_COUNT: byteCount[wrCh] <= strbMerge(byteCount[wrCh], wrData, wrStrb);
          default: ;
        endcase
      end
      if (state == ENG_STEP) begin
        srcAddr[cur] <= stepAddr(srcAddr[cur], curCtl[CTL_SRC_STEP_LSB +: 2], unitBytes);
        dstAddr[cur] <= stepAddr(dstAddr[cur], curCtl[CTL_DST_STEP_LSB +: 2], unitBytes);
        byteCount[cur] <= curCount - unitBytes;
      end
    end
  end

  // Status flags; hardware set wins over write-one-to-clear
  wire stepDone = state == ENG_STEP && curCount == unitBytes;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      active <= '0;
      normalDone <= '0;
      abnormalDone <= '0;
      confErr <= '0;
      normalDoneIrq <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wrEn && wrReg == REG_STATUS && wrCh == 2'(i) && wrStrb[0]) begin
          normalDone[i] <= normalDone[i] & ~wrData[ST_NORMAL_DONE];
          abnormalDone[i] <= abnormalDone[i] & ~wrData[ST_ABNORMAL_DONE];
          confErr[i] <= confErr[i] & ~wrData[ST_CONF_ERR];
        end
        if (goAccept && wrCh == 2'(i)) begin
          if (goErr) begin
            abnormalDone[i] <= 1'b1;
            confErr[i] <= 1'b1;
          end else begin
            active[i] <= 1'b1;
          end
        end
        if (stepDone && cur == 2'(i)) begin
          normalDone[i] <= 1'b1;
          active[i] <= 1'b0;
        end
        normalDoneIrq[i] <= normalDone[i] && ctl[i][CTL_NORMAL_IRQ_EN];
      end
    end
  end

  // Checks
  a_read_then_write: assert property (@(posedge clk) disable iff (!resetn)
    $rose(state == ENG_WRITE) |-> $past(state) == ENG_READ && $past(sysReady))
    else $error("write phase entered without completed read");
  a_grant_first: assert property (@(posedge clk) disable iff (!resetn)
    $rose(state == ENG_READ) |-> $past(busGrant) && busReq)
    else $error("transfer began without bus grant");
  a_io_addr_fixed: assert property (@(posedge clk) disable iff (!resetn)
    (state == ENG_READ && sysValid && curCtl[CTL_SRC_IO]) |-> sysAddr == srcAddr[cur])
    else $error("io source address moved");
  a_io_port_size: assert property (@(posedge clk) disable iff (!resetn)
    (state == ENG_READ && sysValid && curCtl[CTL_SRC_IO])
      |-> sysSize == logCode(portLog))
    else $error("io access not at port width");
  a_count_step: assert property (@(posedge clk) disable iff (!resetn)
    state == ENG_STEP |=> curCount == $past(curCount) - $past(unitBytes))
    else $error("byte count not stepped by unit");
  a_go_ready: assert property (@(posedge clk) disable iff (!resetn)
    (goAccept && !goErr) |=> active[wrCh] && !abnormalDone[wrCh])
    else $error("good start did not set active");
  a_cfg_abort: assert property (@(posedge clk) disable iff (!resetn)
    (goAccept && goErr) |=> abnormalDone[wrCh] && !active[wrCh] && state != ENG_READ)
    else $error("bad start not terminated abnormally");
  a_normal_end: assert property (@(posedge clk) disable iff (!resetn)
    stepDone |=> normalDone[cur] && !active[cur] && curCount == 32'h0)
    else $error("normal termination missing");
  a_lowest_first: assert property (@(posedge clk) disable iff (!resetn)
    (state == ENG_IDLE && reqVec[0]) |=> cur == 2'd0)
    else $error("channel zero not served first");
  a_irq_enable: assert property (@(posedge clk) disable iff (!resetn)
    !ctl[cur][CTL_NORMAL_IRQ_EN] && $stable(ctl[cur]) |=> !normalDoneIrq[cur])
    else $error("interrupt raised while disabled");
  c_internal_done: cover property (@(posedge clk) disable iff (!resetn)
    stepDone && !curCtl[CTL_EXT_REQ]);
  c_external_done: cover property (@(posedge clk) disable iff (!resetn)
    stepDone && curCtl[CTL_EXT_REQ]);
  c_config_error: cover property (@(posedge clk) disable iff (!resetn) goAccept && goErr);
  c_narrow_io: cover property (@(posedge clk) disable iff (!resetn)
    state == ENG_READ && sysReady && phaseIo && beat == 2'd3);
endmodule
`default_nettype wire

// ---- dma_dual_address_pkg.sv ----
// Constants shared by the dual-address DMA channel engine
`default_nettype none
package dma_dual_address_pkg;
  // Register index inside one channel window (byte address bits [4:2])
  localparam logic [2:0] REG_CONTROL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_SOURCE = 3'h2;
  localparam logic [2:0] REG_DEST = 3'h3;
  localparam logic [2:0] REG_COUNT = 3'h4;
  localparam int CH_ADDR_LSB = 5;
  localparam int REG_ADDR_LSB = 2;
  // channel_control_reg fields
  localparam int CTL_GO = 0;
  localparam int CTL_EXT_REQ = 1;
  localparam int CTL_UNIT_LSB = 2;
  localparam int CTL_PORT_LSB = 4;
  localparam int CTL_SRC_IO = 6;
  localparam int CTL_DST_IO = 7;
  localparam int CTL_SRC_STEP_LSB = 8;
  localparam int CTL_DST_STEP_LSB = 10;
  localparam int CTL_NORMAL_IRQ_EN = 12;
  localparam int CTL_ADDR_MODE = 15;
  localparam logic [31:0] CTL_WRITE_MASK = 32'h00009FFE;
  // channel_status_reg fields
  localparam int ST_ACTIVE = 0;
  localparam int ST_NORMAL_DONE = 1;
  localparam int ST_ABNORMAL_DONE = 2;
  localparam int ST_CONF_ERR = 3;
  // Size codes: 0x = 32 bits, 10 = 16 bits, 11 = 8 bits
  localparam logic [1:0] SIZE_16 = 2'h2;
  // Address step codes
  localparam logic [1:0] STEP_INC = 2'h0;
  localparam logic [1:0] STEP_DEC = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  typedef enum logic [2:0] {
    ENG_IDLE = 3'b000,
    ENG_ARB = 3'b001,
    ENG_READ = 3'b010,
    ENG_WRITE = 3'b011,
    ENG_STEP = 3'b100
  } engine_e;
endpackage
`default_nettype wire

// ---- sys_bus_model.sv ----
// System bus partner: byte memory plus one fixed-address I/O port
`default_nettype none
module sys_bus_model
  import dma_dual_address_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic busReq,
  output logic busGrant,
  input wire logic sysValid,
  input wire logic sysWrite,
  input wire logic [31:0] sysAddr,
  input wire logic [1:0] sysSize,
  input wire logic [31:0] sysWdata,
  output logic [31:0] sysRdata,
  output logic sysReady,
  output logic [7:0] ioCount,
  output logic [7:0] beats
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] IO_ADDR = 8'h80;
  logic [7:0] mem [0:255];
  logic [31:0] tmp;
  logic slow;
  int n;
  always @(posedge clk) begin
    busGrant <= resetn && busReq;
    sysReady <= 1'b0;
    // Idle data lanes never hold the last value
    sysRdata <= ~sysRdata;
    if (!resetn) begin
      ioCount <= 8'h00;
      beats <= 8'h00;
      slow <= 1'b0;
      sysRdata <= 32'h00000000;
    end else if (sysValid && !sysReady) begin
      slow <= ~slow;
      if (slow) begin
        sysReady <= 1'b1;
        beats <= beats + 8'h01;
        n = (sysSize == 2'h3) ? 1 : (sysSize == SIZE_16) ? 2 : 4;
        tmp = ~sysRdata;
        if (sysAddr[7:0] == IO_ADDR) ioCount <= ioCount + 8'h01;
        for (int i = 0; i < n; i++) begin
          if (sysWrite) mem[sysAddr[7:0] + 8'(i)] <= sysWdata[8*i +: 8];
          else tmp[8*i +: 8] = (sysAddr[7:0] == IO_ADDR) ? ioCount : mem[sysAddr[7:0] + 8'(i)];
        end
        if (!sysWrite) sysRdata <= tmp;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dma_dual_address_channel_test.sv ----
// Self-checking bench for the dual-address DMA channel engine
`default_nettype none
module dma_dual_address_channel_test
  import dma_dual_address_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic busReq, busGrant, sysValid, sysWrite, sysReady;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ioCount, beats;
  logic [31:0] s_axi_wdata, s_axi_rdata, sysAddr, sysWdata, sysRdata, rd;
  logic [3:0] s_axi_wstrb, extTransferRequestN, normalDoneIrq;
  logic [1:0] s_axi_bresp, s_axi_rresp, memBusWidth, sysSize, rsp;
  logic [31:0] badCtl [4] = '{32'h1, 32'h8001, 32'h4D, 32'h6D};
  logic [31:0] badCnt [4] = '{32'h0, 32'h4, 32'h4, 32'h4};
  int failures, total_checks;
  dma_dual_address_channel u_dma_dual_address_channel (.clk, .resetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .extTransferRequestN, .memBusWidth, .busReq, .busGrant, .sysValid, .sysWrite, .sysAddr,
    .sysSize, .sysWdata, .sysRdata, .sysReady, .normalDoneIrq);
  sys_bus_model u_sys_bus_model (.clk, .resetn, .busReq, .busGrant, .sysValid, .sysWrite,
    .sysAddr, .sysSize, .sysWdata, .sysRdata, .sysReady, .ioCount, .beats);
  function automatic logic [7:0] ra(input int ch, input int idx);
    return 8'(ch * 32 + idx * 4);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    check(rd, exp);
  endtask
  task automatic setup_channel(input int ch, input logic [31:0] src, dst, cnt, ctl);
    axi_write(ra(ch, 2), src);
    axi_write(ra(ch, 3), dst);
    axi_write(ra(ch, 4), cnt);
    axi_write(ra(ch, 0), ctl);
  endtask
  task automatic wait_done(input int ch);
    do begin
      axi_read(ra(ch, 1));
    end while (rd[2:1] == 2'b00);
  endtask
  task automatic close_out();
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #80000;
    failures++;
    close_out();
  end
  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    extTransferRequestN = 4'hF;
    memBusWidth = SIZE_16;
    for (int i = 0; i < 256; i++) begin
      u_sys_bus_model.mem[i] = 8'(i) ^ 8'h5A;
    end
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    read_check(ra(0, 1), 32'h0);
    read_check(ra(0, 5), 32'h0);
    check(32'(rsp), 32'(RESP_SLVERR));
    // Memory to memory, internal request, 16-bit memory
    setup_channel(0, 32'h0, 32'h40, 32'h8, 32'h1001);
    wait_done(0);
    check(rd, 32'h2);
    check(32'(beats), 32'h8);
    for (int i = 0; i < 8; i++) begin
      check(32'(u_sys_bus_model.mem[8'h40 + 8'(i)]), 32'(8'(i) ^ 8'h5A));
    end
    read_check(ra(0, 2), 32'h8);
    read_check(ra(0, 3), 32'h48);
    read_check(ra(0, 4), 32'h0);
    check(32'(normalDoneIrq), 32'h1);
    axi_write(ra(0, 0), 32'h1001);
    read_check(ra(0, 1), 32'hE);
    axi_write(ra(0, 1), 32'hE);
    read_check(ra(0, 1), 32'h0);
    // Configuration errors: zero count, address mode, port above unit
    foreach (badCtl[k]) begin
      setup_channel(1, 32'h0, 32'h20, badCnt[k], badCtl[k]);
      read_check(ra(1, 1), 32'hC);
      read_check(ra(1, 4), badCnt[k]);
      axi_write(ra(1, 1), 32'hC);
    end
    check(32'(beats), 32'h8);
    // Memory to memory, 8-bit unit, both addresses counting down
    setup_channel(1, 32'h7, 32'h57, 32'h2, 32'h50D);
    wait_done(1);
    check(rd, 32'h2);
    check({16'h0, u_sys_bus_model.mem[8'h57], u_sys_bus_model.mem[8'h56]}, 32'h5D5C);
    check(32'(beats), 32'hC);
    read_check(ra(1, 2), 32'h5);
    read_check(ra(1, 3), 32'h55);
    check(32'(normalDoneIrq), 32'h0);
    // I/O to memory, 8-bit port, 32-bit unit, external request
    setup_channel(2, 32'h80, 32'h60, 32'h4, 32'h273);
    read_check(ra(2, 1), 32'h1);
    check(32'(ioCount), 32'h0);
    check(32'(busReq), 32'h0);
    extTransferRequestN <= 4'hB;
    wait_done(2);
    extTransferRequestN <= 4'hF;
    check(rd, 32'h2);
    check(32'(ioCount), 32'h4);
    check({u_sys_bus_model.mem[8'h63], u_sys_bus_model.mem[8'h62], u_sys_bus_model.mem[8'h61],
      u_sys_bus_model.mem[8'h60]}, 32'h03020100);
    read_check(ra(2, 2), 32'h80);
    read_check(ra(2, 3), 32'h64);
    // Memory to I/O, port equal to 16-bit unit
    setup_channel(3, 32'h10, 32'h80, 32'h2, 32'h8AB);
    extTransferRequestN <= 4'h7;
    wait_done(3);
    extTransferRequestN <= 4'hF;
    check(32'(ioCount), 32'h5);
    check({16'h0, u_sys_bus_model.mem[8'h81], u_sys_bus_model.mem[8'h80]}, 32'h4B4A);
    close_out();
  end
endmodule
`default_nettype wire
